// [hw/psp_host.sv]
// Purpose: Host controller driving an asynchronous page pseudo-static RAM.
// Assumes: Pins sampled synchronously to clk; one request at a time.
// Notes: Times are counted in 50 ns cycles, so every edge is slow but safe.

module psp_host
  import psp_pkg::*;
#(
  parameter int ADDR_WIDTH = 21,
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int RECOVERY_CYCLES = RECOVERY_CYC,
  parameter int SLEEP_CYCLES = SLEEP_MIN_CYC,
  parameter int BURST_CYCLES = BURST_LIMIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_WIDTH-1:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic [1:0] req_lanes,
  input wire logic [4:0] req_count,
  output logic req_ready,
  output logic [15:0] rsp_rdata,
  output logic rsp_valid,
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  output logic deep_sleep_state,
  output logic data_lost,
  output logic ram_select_n,
  output logic ram_write_strobe_n,
  output logic ram_output_enable_n,
  output logic upper_lane_select_n,
  output logic lower_lane_select_n,
  output logic sleep_request_n,
  output logic [ADDR_WIDTH-1:0] ram_addr,
  output logic [15:0] ram_data_out,
  output logic ram_data_oe,
  input wire logic [15:0] ram_data_in
);

  localparam int TW = 16;

  initial begin
    if (ADDR_WIDTH < PAGE_BITS + 1 || POWERUP_CYCLES >= 2 ** TW ||
        RECOVERY_CYCLES >= 2 ** TW || SLEEP_CYCLES >= 2 ** TW ||
        BURST_CYCLES >= 2 ** TW || BURST_CYCLES < 2) begin
      $error("psp_host: parameter out of range");
    end
  end

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ****************************************************************
  // Timer
  // ****************************************************************
  psp_state_t state;
  logic tmr_load;
  logic [TW-1:0] tmr_value;
  logic tmr_done;
  logic [4:0] words_left;
  logic [2:0] phase;
  logic [TW-1:0] burst;
  logic burst_rest;
  logic first_word;
  logic read_step;

  psp_timer #(.WIDTH(TW)) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(tmr_load),
    .value(tmr_value),
    .done(tmr_done)
  );

  function automatic logic [TW-1:0] cyc(input int n);
    return n[TW-1:0];
  endfunction : cyc

  always_comb begin
    tmr_load = 1'b0;
    tmr_value = '0;
    unique case (state)
      PSP_SLEEP_ENTRY: begin
        tmr_load = 1'b1;
        tmr_value = cyc(SLEEP_CYCLES);
      end
      PSP_SLEEP: begin
        if (sleep_exit && tmr_done) begin
          tmr_load = 1'b1;
          tmr_value = cyc(RECOVERY_CYCLES);
        end
      end
      default: begin
      end
    endcase
  end

  // Long runs of back-to-back cycles get one idle rest before the limit.
  assign burst_rest = (burst >= cyc(BURST_CYCLES - 1));
  assign req_ready = (state == PSP_IDLE) && !burst_rest && !sleep_enter;

  // The pins fall one edge after the read state is entered, so the first word waits
  // the full access time from there; later words only wait the page time.
  assign read_step = (state == PSP_READ) &&
                     (phase == (first_word ? 3'(CYCLE_MIN_CYC) : 3'(PAGE_CYC - 1)));

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PSP_WAIT_UP;
      phase <= '0;
      words_left <= '0;
      first_word <= 1'b0;
    end else begin
      unique case (state)
        PSP_WAIT_UP: begin
          if (up_count == cyc(POWERUP_CYCLES)) begin
            state <= PSP_IDLE;
          end
        end
        PSP_IDLE: begin
          phase <= '0;
          if (sleep_enter) begin
            state <= PSP_SLEEP_ENTRY;
          end else if (req_valid && req_ready) begin
            state <= req_write ? PSP_WRITE : PSP_READ;
            first_word <= 1'b1;
            words_left <= (req_count == 5'd0) ? 5'd1 :
                          (req_count > 5'(PAGE_WORDS)) ? 5'(PAGE_WORDS) : req_count;
          end
        end
        PSP_READ: begin
          phase <= phase + 3'd1;
          if (read_step) begin
            phase <= '0;
            first_word <= 1'b0;
            words_left <= words_left - 5'd1;
            if (words_left == 5'd1) begin
              state <= PSP_GAP;
            end
          end
        end
        PSP_WRITE: begin
          phase <= phase + 3'd1;
          if (phase == 3'(WRITE_PULSE_CYC)) begin
            state <= PSP_GAP;
          end
        end
        PSP_GAP: begin
          state <= PSP_IDLE;
        end
        PSP_SLEEP_ENTRY: begin
          state <= PSP_SLEEP;
        end
        PSP_SLEEP: begin
          if (sleep_exit && tmr_done) begin
            state <= PSP_RECOVER;
          end
        end
        PSP_RECOVER: begin
          if (tmr_done) begin
            state <= PSP_IDLE;
          end
        end
      endcase
    end
  end

  // Power-up wait is counted by a plain counter so the shared timer stays simple.
  logic [TW-1:0] up_count;


  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_count <= '0;
    end else if (state == PSP_WAIT_UP && up_count != cyc(POWERUP_CYCLES)) begin
      up_count <= up_count + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      burst <= '0;
    end else if (state == PSP_IDLE && !(req_valid && req_ready)) begin
      burst <= '0;
    end else if (state != PSP_IDLE) begin
      burst <= burst + 1'b1;
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  logic access;

  assign access = (state == PSP_READ) || (state == PSP_WRITE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_select_n <= 1'b1;
      ram_write_strobe_n <= 1'b1;
      ram_output_enable_n <= 1'b1;
      upper_lane_select_n <= 1'b1;
      lower_lane_select_n <= 1'b1;
      sleep_request_n <= 1'b1;
      ram_addr <= '0;
      ram_data_out <= '0;
      ram_data_oe <= 1'b0;
    end else begin
      // Select stays low one cycle past the strobe so the strobe alone ends the write.
      ram_select_n <= !access;
      ram_write_strobe_n <= !((state == PSP_WRITE && phase < 3'(WRITE_PULSE_CYC)) ||
                              state == PSP_SLEEP_ENTRY || state == PSP_SLEEP);
      ram_output_enable_n <= !(state == PSP_READ);
      sleep_request_n <= !(state == PSP_SLEEP_ENTRY || state == PSP_SLEEP ||
                           (state == PSP_IDLE && sleep_enter));
      ram_data_oe <= (state == PSP_WRITE) || (state == PSP_IDLE && req_valid && req_ready &&
                                                req_write);
      if (state == PSP_IDLE && req_valid && req_ready) begin
        ram_addr <= req_addr;
        ram_data_out <= req_wdata;
        upper_lane_select_n <= req_write ? !req_lanes[1] : 1'b0;
        lower_lane_select_n <= req_write ? !req_lanes[0] : 1'b0;
      end else if (read_step && words_left != 5'd1) begin
        ram_addr[PAGE_BITS-1:0] <= ram_addr[PAGE_BITS-1:0] + 1'b1;
      end else if (!access) begin
        upper_lane_select_n <= 1'b1;
        lower_lane_select_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= read_step;
      if (read_step) begin
        rsp_rdata <= ram_data_in;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deep_sleep_state <= 1'b0;
      data_lost <= 1'b0;
    end else begin
      deep_sleep_state <= (state == PSP_SLEEP_ENTRY) || (state == PSP_SLEEP) ||
                          (state == PSP_RECOVER);
      if (state == PSP_SLEEP_ENTRY) begin
        data_lost <= 1'b1;
      end else if (state == PSP_IDLE && req_valid && req_ready && req_write) begin
        data_lost <= 1'b0;
      end
    end
  end

endmodule : psp_host

// [hw/psp_timer.sv]
// Purpose: Loadable down counter for waits of the controller.
// Assumes: Load wins over counting.
// Notes: done is high while the count is zero.
module psp_timer
  import psp_pkg::*;
#(
  parameter int WIDTH = 13
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] value,
  output logic done
);

  logic [WIDTH-1:0] count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done = (count == '0);

endmodule : psp_timer

// [include/psp_pkg.sv]
// Purpose: Constants shared by the pseudo-static RAM host controller.
// Assumes: 20 MHz clock, one clock domain.
// Notes: Times are kept in their own unit; cycle counts derive from them.
package psp_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int POWERUP_US = 200;
  localparam int RECOVERY_US = 200;
  localparam int SLEEP_MIN_US = 10;
  localparam int SLEEP_TO_STROBE_MAX_US = 1;
  localparam int BURST_LIMIT_US = 20;
  localparam int CYCLE_MIN_NS = 70;
  localparam int PAGE_CYCLE_NS = 25;
  localparam int WRITE_PULSE_NS = 50;
  localparam int POWERUP_CYC = (POWERUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC = (RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_MIN_CYC = (SLEEP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest times round down; the strobe follows the sleep request one cycle later.
  localparam int SLEEP_TO_STROBE_CYC = 1;
  localparam int BURST_LIMIT_CYC = (BURST_LIMIT_US * 1000) / CLK_PERIOD_NS;
  localparam int CYCLE_MIN_CYC = (CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_CYC_RAW = (PAGE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_CYC = (PAGE_CYC_RAW < 1) ? 1 : PAGE_CYC_RAW;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // One idle cycle before a run of minimum cycles grows longer than the limit.
  localparam int BURST_REST_CYC = 1;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int PAGE_WORDS = 16;
  localparam int PAGE_BITS = 4;

  typedef enum logic [2:0] {
    PSP_WAIT_UP = 3'b000,
    PSP_IDLE = 3'b001,
    PSP_READ = 3'b011,
    PSP_WRITE = 3'b010,
    PSP_GAP = 3'b110,
    PSP_SLEEP_ENTRY = 3'b111,
    PSP_SLEEP = 3'b101,
    PSP_RECOVER = 3'b100
  } psp_state_t;

endpackage : psp_pkg

// [tb/psp_host_properties.sv]
// Purpose: Pin timing checks bound into psp_host.
// Assumes: One clock; reset_n low clears the counters.
// Notes: Long waits are measured with saturating counters.
module psp_host_props #(
  parameter int ADDR_WIDTH = 21,
  parameter int POWERUP_CYCLES = 20,
  parameter int SLEEP_CYCLES = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ram_select_n,
  input wire logic ram_write_strobe_n,
  input wire logic ram_output_enable_n,
  input wire logic upper_lane_select_n,
  input wire logic lower_lane_select_n,
  input wire logic sleep_request_n,
  input wire logic [ADDR_WIDTH-1:0] ram_addr,
  input wire logic ram_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Cycles since reset or wake, and cycles asleep; both saturate so they never wrap.
  logic [15:0] awake;
  logic [15:0] asleep;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awake <= 16'h0000;
      asleep <= 16'h0000;
    end else begin
      awake <= !sleep_request_n ? 16'h0000 : awake + {15'h0000, awake != 16'hffff};
      asleep <= sleep_request_n ? 16'h0000 : asleep + {15'h0000, asleep != 16'hffff};
    end
  end
  property p_wait; !ram_select_n |-> awake >= POWERUP_CYCLES; endproperty
  a_wait: assert property (p_wait) else $error("select low too early");
  property p_recover; $rose(sleep_request_n) |-> (ram_select_n && ram_write_strobe_n) [*8];
  endproperty
  a_recover: assert property (p_recover) else $error("access during recovery");
  property p_sleep_hold; $rose(sleep_request_n) |-> asleep >= SLEEP_CYCLES; endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep too short");
  property p_sleep_strobe; $fell(sleep_request_n) |=> !ram_write_strobe_n; endproperty
  a_sleep_strobe: assert property (p_sleep_strobe) else $error("no strobe in sleep");
  property p_page; !ram_output_enable_n && !ram_select_n |-> ram_write_strobe_n && sleep_request_n;
  endproperty
  a_page: assert property (p_page) else $error("read with strobe or sleep low");
  property p_page_addr; !ram_select_n && !ram_output_enable_n && !$past(ram_select_n)
    && !$past(ram_output_enable_n) |-> ram_addr[ADDR_WIDTH-1:4] == $past(ram_addr[ADDR_WIDTH-1:4]);
  endproperty
  a_page_addr: assert property (p_page_addr) else $error("page left in a read");
  property p_wr_start; $fell(ram_write_strobe_n) && sleep_request_n |-> !ram_select_n
    && ram_data_oe && !(upper_lane_select_n && lower_lane_select_n);
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("bad write start");
  property p_wr_end; $rose(ram_write_strobe_n) && $past(sleep_request_n) |-> !ram_select_n
    ##1 ram_select_n;
  endproperty
  a_wr_end: assert property (p_wr_end) else $error("bad write end");
  property p_standby; ram_select_n && sleep_request_n |-> ram_write_strobe_n; endproperty
  a_standby: assert property (p_standby) else $error("strobe low in standby");
  c_read: cover property (!ram_output_enable_n && !ram_select_n);
  c_byte: cover property (!ram_write_strobe_n && upper_lane_select_n != lower_lane_select_n);
  c_wake: cover property ($rose(sleep_request_n));
endmodule : psp_host_props

bind psp_host psp_host_props #(.ADDR_WIDTH(ADDR_WIDTH), .POWERUP_CYCLES(POWERUP_CYCLES),
  .SLEEP_CYCLES(SLEEP_CYCLES)) psp_host_props_i (.clk(clk), .reset_n(reset_n),
  .ram_select_n(ram_select_n), .ram_write_strobe_n(ram_write_strobe_n),
  .ram_output_enable_n(ram_output_enable_n), .upper_lane_select_n(upper_lane_select_n),
  .lower_lane_select_n(lower_lane_select_n), .sleep_request_n(sleep_request_n),
  .ram_addr(ram_addr), .ram_data_oe(ram_data_oe));

// [tb/psp_host_tb.sv]
// Purpose: Self-checking bench for psp_host.
// Assumes: Waits cut to a few cycles by parameters.
// Notes: Inputs move on rising edges only.
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module psp_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WAIT_N = 20;
  logic clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic sleep_enter = 1'b0, sleep_exit = 1'b0;
  logic [20:0] req_addr = 21'h00_0000;
  logic [15:0] req_wdata = 16'h0000;
  logic [1:0] req_lanes = 2'b11;
  logic [4:0] req_count = 5'h01;
  logic req_ready, rsp_valid, deep_sleep_state, data_lost, ram_select_n, ram_data_oe;
  logic ram_write_strobe_n, ram_output_enable_n, upper_lane_select_n, lower_lane_select_n;
  logic sleep_request_n;
  logic [20:0] ram_addr;
  logic [15:0] rsp_rdata, ram_data_out, ram_data_in;
  logic [15:0] exp_mem [0:255];
  int n_errors = 0, total_checks = 0;
  always #25 clk = ~clk;
  psp_host #(.POWERUP_CYCLES(WAIT_N), .RECOVERY_CYCLES(WAIT_N), .SLEEP_CYCLES(5),
    .BURST_CYCLES(10)) psp_host_i (.*);
  psp_ram_model psp_ram_model_i (.*);

  task automatic complete_run(input int bad);
    n_errors += bad;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic wait_ready(output int n);
    for (n = 0; n < 5000; n++) begin
      @(negedge clk);
      if (req_ready === 1'b1) break;
    end
    if (n == 5000) complete_run(1);
  endtask : wait_ready

  task automatic issue(input logic wr, input logic [20:0] a, input logic [15:0] d,
    input logic [1:0] ln, input logic [4:0] cnt);
    int n;
    @(posedge clk);
    {req_valid, req_write, req_addr, req_wdata, req_lanes, req_count} <= {1'b1, wr, a, d, ln, cnt};
    wait_ready(n);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask : issue

  task automatic page_read(input logic [20:0] a, input int cnt);
    int got;
    int exp_n;
    got = 0;
    // A count of zero reads one word, and counts above a page are clipped to 16.
    exp_n = (cnt == 0) ? 1 : ((cnt > 16) ? 16 : cnt);
    issue(1'b0, a, 16'h0000, 2'b11, cnt[4:0]);
    for (int i = 0; i < 60 && got < exp_n; i++) begin
      @(negedge clk);
      if (rsp_valid === 1'b1) begin
        `CHK(rsp_rdata, exp_mem[{a[7:4], a[3:0] + got[3:0]}])
        got++;
      end
    end
    `CHK(got, exp_n)
    repeat (2) begin
      @(negedge clk);
      `CHK(rsp_valid, 1'b0)
    end
  endtask : page_read

  task automatic t_write_read();
    logic [7:0] k;
    for (int i = 0; i < 16; i++) begin
      k = 8'h20 + i[7:0];
      exp_mem[k] = 16'h1100 + {8'h00, k};
      issue(1'b1, {13'h0000, k}, exp_mem[k], 2'b11, 5'h01);
    end
    issue(1'b1, 21'h00_0023, 16'haaaa, 2'b01, 5'h01);
    exp_mem[8'h23][7:0] = 8'haa;
    issue(1'b1, 21'h00_0025, 16'h5555, 2'b10, 5'h01);
    exp_mem[8'h25][15:8] = 8'h55;
    page_read(21'h00_0020, 16);
    page_read(21'h00_002e, 4);
    page_read(21'h00_0024, 0);
    page_read(21'h00_0020, 20);
    $display("write and page read test done");
  endtask : t_write_read

  task automatic t_sleep();
    int n;
    // Let the gap cycle after the last read raise the select first.
    repeat (2) @(negedge clk);
    `CHK({ram_select_n, ram_write_strobe_n, sleep_request_n}, 3'b111)
    @(posedge clk);
    sleep_enter <= 1'b1;
    for (n = 0; n < 50 && deep_sleep_state !== 1'b1; n++) @(negedge clk);
    if (n == 50) complete_run(1);
    @(posedge clk);
    sleep_enter <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK({sleep_request_n, ram_write_strobe_n, deep_sleep_state}, 3'b001)
    repeat (8) @(posedge clk);
    sleep_exit <= 1'b1;
    wait_ready(n);
    `CHK(n >= WAIT_N, 1'b1)
    `CHK(data_lost, 1'b1)
    @(posedge clk);
    sleep_exit <= 1'b0;
    exp_mem[8'h40] = 16'h0bee;
    issue(1'b1, 21'h00_0040, 16'h0bee, 2'b11, 5'h01);
    page_read(21'h00_0040, 1);
    `CHK(data_lost, 1'b0)
    $display("deep sleep test done");
  endtask : t_sleep

  initial begin
    int n;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    wait_ready(n);
    `CHK(n >= WAIT_N, 1'b1)
    $display("power-up test done");
    t_write_read();
    t_sleep();
    complete_run(0);
  end
endmodule : psp_host_tb

// [tb/psp_ram_model.sv]
// Purpose: Behavioural pseudo-static RAM facing psp_host.
// Assumes: Only 256 words, picked by the low address bits.
// Notes: A released bus shows the inverse of the last word.
module psp_ram_model (
  input wire logic ram_select_n,
  input wire logic ram_write_strobe_n,
  input wire logic ram_output_enable_n,
  input wire logic upper_lane_select_n,
  input wire logic lower_lane_select_n,
  input wire logic sleep_request_n,
  input wire logic [20:0] ram_addr,
  input wire logic [15:0] ram_data_out,
  input wire logic ram_data_oe,
  output logic [15:0] ram_data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:255];
  logic [15:0] held = 16'h5a5a;
  wire logic writing = !ram_select_n && !ram_write_strobe_n && sleep_request_n;
  wire logic driving = !ram_select_n && !ram_output_enable_n && ram_write_strobe_n
    && sleep_request_n;
  assign ram_data_in = ram_data_oe ? ram_data_out : (driving ? mem[ram_addr[7:0]] : held);
  // The word lands when the overlap ends, whichever pin rose first.
  always @(negedge writing) begin
    if (!upper_lane_select_n) mem[ram_addr[7:0]][15:8] = ram_data_in[15:8];
    if (!lower_lane_select_n) mem[ram_addr[7:0]][7:0] = ram_data_in[7:0];
  end
  always @(negedge driving) held = ~mem[ram_addr[7:0]];
  // Deep sleep stops refresh, so every word is disturbed on wake.
  always @(posedge sleep_request_n) begin
    for (int i = 0; i < 256; i++) mem[i] = ~mem[i];
  end
endmodule : psp_ram_model
